// File: core/serial_lines_defs.svh
// Constants for the two-channel serial line and modem pin block.
`ifndef SERIAL_LINES_DEFS_SVH
`define SERIAL_LINES_DEFS_SVH
`define AUTO_RTS_BIT 6
`define AUTO_CTS_BIT 7
`define CTRL_RTS_BIT 1
`define CTRL_DTR_BIT 0
`define RTS_IRQ_EN_BIT 6
`define CTS_IRQ_EN_BIT 7
`define STAT_CTS_BIT 4
`define STAT_DSR_BIT 5
`define STAT_RI_BIT 6
`define STAT_CD_BIT 7
`define STAT_DCTS_BIT 0
`define STATUS_RESET 8'h00
`define MARK_LEVEL 1'b1
`endif

// File: core/serial_lines_pkg.sv
// Types shared by the serial line and modem pin block.
`default_nettype none
package serial_lines_pkg;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_SEND = 2'b01,
    TX_HOLD = 2'b10
  } tx_gate_e;
endpackage
`default_nettype wire

// File: core/pin_sync.sv
// Two-flop synchroniser for a bundle of asynchronous pin inputs.
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [WIDTH-1:0] async_in,
  input wire logic [WIDTH-1:0] reset_val_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;

  // A zero width would leave the synchroniser with nothing to carry.
  if (WIDTH < 1) begin : g_bad_width
    $error("pin_sync width must be positive");
  end

  // Each bit passes two flops; reset loads the idle value via a clocked load.
  generate
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
          meta_reg[i] <= reset_val_in[i];
          sync_out[i] <= reset_val_in[i];
        end else begin
          meta_reg[i] <= async_in[i];
          sync_out[i] <= meta_reg[i];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// File: core/serial_lines.sv
// Serial data and modem handshake pins of both channels, with flow control.
`timescale 1ns/1ns
`default_nettype none
`include "serial_lines_defs.svh"
module serial_lines
  import serial_lines_pkg::*;
#(
  parameter int CHANNELS = 2
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Core side: per-channel transmit stream (mark high) and busy flag.
  input wire logic [CHANNELS-1:0] core_tx_in,
  input wire logic [CHANNELS-1:0] core_tx_busy_in,
  input wire logic [CHANNELS-1:0] rts_level_in,
  input wire logic [7:0] enhanced_feature_a_in,
  input wire logic [7:0] enhanced_feature_b_in,
  input wire logic [7:0] modem_control_a_in,
  input wire logic [7:0] modem_control_b_in,
  input wire logic [7:0] interrupt_enable_a_in,
  input wire logic [7:0] interrupt_enable_b_in,
  // Line pins.
  output logic line_tx_chan_a_out,
  output logic line_tx_chan_b_out,
  input wire logic line_rx_chan_a_in,
  input wire logic line_rx_chan_b_in,
  input wire logic logic_rx_chan_b_in,
  input wire logic rx_source_select_b_in,
  output logic logic_tx_chan_b_out,
  output logic req_to_send_chan_a_out,
  output logic req_to_send_chan_b_out,
  input wire logic clear_to_send_chan_a_in,
  input wire logic clear_to_send_chan_b_in,
  output logic term_ready_chan_a_out,
  output logic term_ready_chan_b_out,
  input wire logic set_ready_chan_a_in,
  input wire logic set_ready_chan_b_in,
  input wire logic carrier_detect_chan_a_in,
  input wire logic carrier_detect_chan_b_in,
  input wire logic ring_ind_chan_a_in,
  input wire logic ring_ind_chan_b_in,
  // Core side results.
  output logic [CHANNELS-1:0] core_rx_out,
  output logic [CHANNELS-1:0] tx_allowed_out,
  output logic [7:0] modem_status_a_out,
  output logic [7:0] modem_status_b_out,
  output logic [CHANNELS-1:0] cts_irq_out,
  output logic [CHANNELS-1:0] rts_irq_out
);
  // The pin map below is written for exactly two channels.
  if (CHANNELS != 2) begin : g_bad_channels
    $error("serial_lines serves exactly two channels");
  end

  // Pin inputs: rx a, rx b line, rx b logic, sel, cts a/b, dsr/cd/ri a/b.
  logic [11:0] pins_raw;
  logic [11:0] pins_sync;
  logic [11:0] pins_idle;
  assign pins_raw = {ring_ind_chan_b_in, ring_ind_chan_a_in,
                     carrier_detect_chan_b_in, carrier_detect_chan_a_in,
                     set_ready_chan_b_in, set_ready_chan_a_in,
                     clear_to_send_chan_b_in, clear_to_send_chan_a_in,
                     rx_source_select_b_in, logic_rx_chan_b_in,
                     line_rx_chan_b_in, line_rx_chan_a_in};
  // Line inputs idle low; the logic receive input idles at mark.
  assign pins_idle = 12'h004;

  pin_sync #(.WIDTH(12)) u_sync (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .async_in(pins_raw),
    .reset_val_in(pins_idle),
    .sync_out(pins_sync)
  );

  logic rx_a_line, rx_b_line, rx_b_logic, rx_sel;
  logic [1:0] cts_pin, dsr_pin, cd_pin, ri_pin;
  assign rx_a_line = pins_sync[0];
  assign rx_b_line = pins_sync[1];
  assign rx_b_logic = pins_sync[2];
  assign rx_sel = pins_sync[3];
  assign cts_pin = pins_sync[5:4];
  assign dsr_pin = pins_sync[7:6];
  assign cd_pin = pins_sync[9:8];
  assign ri_pin = pins_sync[11:10];

  logic [7:0] feature [CHANNELS];
  logic [7:0] modem_ctrl [CHANNELS];
  logic [7:0] irq_enable [CHANNELS];
  assign feature[0] = enhanced_feature_a_in;
  assign feature[1] = enhanced_feature_b_in;
  assign modem_ctrl[0] = modem_control_a_in;
  assign modem_ctrl[1] = modem_control_b_in;
  assign irq_enable[0] = interrupt_enable_a_in;
  assign irq_enable[1] = interrupt_enable_b_in;

  // Receive path: line level is inverted to mark-high logic; B may pick the
  // logic input instead. A floating line input reads low, i.e. mark.
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      core_rx_out <= {CHANNELS{`MARK_LEVEL}};
    end else begin
      core_rx_out[0] <= ~rx_a_line;
      core_rx_out[1] <= rx_sel ? rx_b_logic : ~rx_b_line;
    end
  end

  // Transmit gating per channel: while busy, the stream starts passing only once auto
  // clear-to-send is off or the partner allows it, then passes until busy ends; otherwise hold at mark.
  tx_gate_e gate_reg [CHANNELS];
  logic [CHANNELS-1:0] tx_mark;
  generate
    for (genvar c = 0; c < CHANNELS; c++) begin : g_tx
      logic allow;
      assign allow = !feature[c][`AUTO_CTS_BIT] || cts_pin[c];
      always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
          gate_reg[c] <= TX_IDLE;
        end else begin
          case (gate_reg[c])
            TX_IDLE: begin
              if (core_tx_busy_in[c]) gate_reg[c] <= allow ? TX_SEND : TX_HOLD;
            end
            TX_SEND: begin
              if (!core_tx_busy_in[c]) gate_reg[c] <= TX_IDLE;
            end
            TX_HOLD: begin
              if (!core_tx_busy_in[c]) gate_reg[c] <= TX_IDLE;
              else if (allow) gate_reg[c] <= TX_SEND;
            end
            default: gate_reg[c] <= TX_IDLE;
          endcase
        end
      end
      // Stream is at mark unless actively sending.
      assign tx_mark[c] = (gate_reg[c] == TX_SEND) ? core_tx_in[c]
                                                   : `MARK_LEVEL;
      always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
          tx_allowed_out[c] <= 1'b0;
          cts_irq_out[c] <= 1'b0;
          rts_irq_out[c] <= 1'b0;
        end else begin
          tx_allowed_out[c] <= allow;
          cts_irq_out[c] <= irq_enable[c][`CTS_IRQ_EN_BIT] &&
            feature[c][`AUTO_CTS_BIT] && !cts_pin[c];
          // The automatic RTS interrupt fires whether or not software raised RTS first.
          rts_irq_out[c] <= irq_enable[c][`RTS_IRQ_EN_BIT] &&
            feature[c][`AUTO_RTS_BIT] && !rts_level_in[c];
        end
      end
    end
  endgenerate

  // Line outputs are the inverted mark stream so they idle low; reset
  // forces them low directly.
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      line_tx_chan_a_out <= 1'b0;
      line_tx_chan_b_out <= 1'b0;
      logic_tx_chan_b_out <= `MARK_LEVEL;
    end else begin
      line_tx_chan_a_out <= ~tx_mark[0];
      line_tx_chan_b_out <= ~tx_mark[1];
      logic_tx_chan_b_out <= tx_mark[1];
    end
  end

  // Handshake outputs follow software bits; request-to-send is also gated by
  // the core RTS level when automatic RTS mode is enabled.
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      req_to_send_chan_a_out <= 1'b0;
      req_to_send_chan_b_out <= 1'b0;
      term_ready_chan_a_out <= 1'b0;
      term_ready_chan_b_out <= 1'b0;
    end else begin
      req_to_send_chan_a_out <= modem_ctrl[0][`CTRL_RTS_BIT] &&
        (!feature[0][`AUTO_RTS_BIT] || rts_level_in[0]);
      req_to_send_chan_b_out <= modem_ctrl[1][`CTRL_RTS_BIT] &&
        (!feature[1][`AUTO_RTS_BIT] || rts_level_in[1]);
      term_ready_chan_a_out <= modem_ctrl[0][`CTRL_DTR_BIT];
      term_ready_chan_b_out <= modem_ctrl[1][`CTRL_DTR_BIT];
    end
  end

  // Status snapshot; unconnected inputs are pulled low and so read zero.
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      modem_status_a_out <= `STATUS_RESET;
      modem_status_b_out <= `STATUS_RESET;
    end else begin
      modem_status_a_out <= {cd_pin[0], ri_pin[0], dsr_pin[0], cts_pin[0],
        3'h0, cts_pin[0] ^ modem_status_a_out[`STAT_CTS_BIT]};
      modem_status_b_out <= {cd_pin[1], ri_pin[1], dsr_pin[1], cts_pin[1],
        3'h0, cts_pin[1] ^ modem_status_b_out[`STAT_CTS_BIT]};
    end
  end

  // Checks.
  a_reset_tx_low: assert property (@(posedge clk_in)
    !rst_b_in |=> !line_tx_chan_a_out && !line_tx_chan_b_out)
    else $error("line transmit not low after reset");
  a_idle_tx_low: assert property (@(posedge clk_in)
    disable iff (!rst_b_in)
    (gate_reg[0] != TX_SEND) |=> !line_tx_chan_a_out)
    else $error("line transmit A not low while idle");
  a_logic_tx_copy: assert property (@(posedge clk_in)
    disable iff (!rst_b_in) ##1 logic_tx_chan_b_out == ~line_tx_chan_b_out)
    else $error("logic transmit B differs from line stream");
  a_rx_select_logic: assert property (@(posedge clk_in)
    disable iff (!rst_b_in) rx_sel |=> core_rx_out[1] == $past(rx_b_logic))
    else $error("receiver B not fed from logic input");
  a_rx_select_line: assert property (@(posedge clk_in)
    disable iff (!rst_b_in) !rx_sel |=> core_rx_out[1] == !$past(rx_b_line))
    else $error("receiver B not fed from line input");
  a_cts_blocks: assert property (@(posedge clk_in)
    disable iff (!rst_b_in)
    enhanced_feature_a_in[`AUTO_CTS_BIT] && !cts_pin[0] &&
    gate_reg[0] == TX_IDLE |=> gate_reg[0] != TX_SEND)
    else $error("transmit started without clear-to-send");
  a_cts_status: assert property (@(posedge clk_in)
    disable iff (!rst_b_in)
    ##1 modem_status_a_out[`STAT_CTS_BIT] == $past(cts_pin[0]))
    else $error("status bit 4 does not track clear-to-send");
  a_dtr_follow: assert property (@(posedge clk_in)
    disable iff (!rst_b_in)
    ##1 term_ready_chan_b_out == $past(modem_control_b_in[`CTRL_DTR_BIT]))
    else $error("terminal-ready B does not follow control bit");
  a_gpi_read: assert property (@(posedge clk_in)
    disable iff (!rst_b_in)
    ##1 modem_status_b_out[`STAT_RI_BIT] == $past(ri_pin[1]))
    else $error("ring input B not reflected in status");
  a_rts_gate: assert property (@(posedge clk_in)
    disable iff (!rst_b_in)
    !modem_control_a_in[`CTRL_RTS_BIT] |=> !req_to_send_chan_a_out)
    else $error("request-to-send raised without software bit");
  c_send_a: cover property (@(posedge clk_in) gate_reg[0] == TX_SEND);
  c_hold_b: cover property (@(posedge clk_in) gate_reg[1] == TX_HOLD);
  c_rx_logic: cover property (@(posedge clk_in) rx_sel && rst_b_in);
endmodule
`default_nettype wire

// File: tb/remote_terminal.sv
// Remote terminal model that drives the serial receive lines of both channels.
`timescale 1ns/1ns
`default_nettype none
module remote_terminal (
  input wire logic clk_in,
  input wire logic bit_a_in,
  input wire logic bit_b_in,
  input wire logic use_logic_b_in,
  output logic line_rx_a_out,
  output logic line_rx_b_out,
  output logic logic_rx_b_out
);
  logic open_toggle_reg = 1'b0;

  // An open pin shows a level that changes every cycle, so a stale value
  // can never pass for the real one.
  always @(posedge clk_in) begin
    open_toggle_reg <= ~open_toggle_reg;
  end

  // Line levels are inverted marks, so an idle mark rests low at the pin.
  assign line_rx_a_out = ~bit_a_in;
  assign line_rx_b_out = use_logic_b_in ? 1'b0 : ~bit_b_in;
  assign logic_rx_b_out = use_logic_b_in ? bit_b_in : open_toggle_reg;
endmodule
`default_nettype wire

// File: tb/dual_uart_serial_modem_lines_test.sv
// Self-checking testbench for the serial line and modem pin block.
`timescale 1ns/1ns
`default_nettype none
module dual_uart_serial_modem_lines_test;
  logic clk_in = 1'b0, rst_b_in = 1'b0, sel_b = 1'b0, bit_a = 1'b1;
  logic bit_b = 1'b1, cts_a = 1'b0, cts_b = 1'b0, dsr_a = 1'b0;
  logic dsr_b = 1'b0, cd_a = 1'b0, cd_b = 1'b0, ri_a = 1'b0, ri_b = 1'b0;
  logic [1:0] core_tx = 2'h3, busy = 2'h0, rts_lvl = 2'h0;
  logic [7:0] feat_a = 8'h00, feat_b = 8'h00, ctrl_a = 8'h00, ctrl_b = 8'h00;
  logic [7:0] irq_en_a = 8'h00, irq_en_b = 8'h00, st_a, st_b;
  logic tx_a, tx_b, ltx_b, rts_a, rts_b, dtr_a, dtr_b, rx_a, rx_b, lrx_b;
  logic [1:0] core_rx, allowed, cts_irq, rts_irq;
  int miscompares = 0;
  int comparisons = 0;

  // The clock runs at 25 MHz.
  always #20 clk_in = ~clk_in;

  remote_terminal far_end (.clk_in(clk_in), .bit_a_in(bit_a),
    .bit_b_in(bit_b), .use_logic_b_in(sel_b), .line_rx_a_out(rx_a),
    .line_rx_b_out(rx_b), .logic_rx_b_out(lrx_b));

  serial_lines uut (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .core_tx_in(core_tx), .core_tx_busy_in(busy), .rts_level_in(rts_lvl),
    .enhanced_feature_a_in(feat_a), .enhanced_feature_b_in(feat_b),
    .modem_control_a_in(ctrl_a), .modem_control_b_in(ctrl_b),
    .interrupt_enable_a_in(irq_en_a), .interrupt_enable_b_in(irq_en_b),
    .line_tx_chan_a_out(tx_a),
    .line_tx_chan_b_out(tx_b), .line_rx_chan_a_in(rx_a),
    .line_rx_chan_b_in(rx_b), .logic_rx_chan_b_in(lrx_b),
    .rx_source_select_b_in(sel_b), .logic_tx_chan_b_out(ltx_b),
    .req_to_send_chan_a_out(rts_a), .req_to_send_chan_b_out(rts_b),
    .clear_to_send_chan_a_in(cts_a), .clear_to_send_chan_b_in(cts_b),
    .term_ready_chan_a_out(dtr_a), .term_ready_chan_b_out(dtr_b),
    .set_ready_chan_a_in(dsr_a), .set_ready_chan_b_in(dsr_b),
    .carrier_detect_chan_a_in(cd_a), .carrier_detect_chan_b_in(cd_b),
    .ring_ind_chan_a_in(ri_a), .ring_ind_chan_b_in(ri_b),
    .core_rx_out(core_rx), .tx_allowed_out(allowed),
    .modem_status_a_out(st_a), .modem_status_b_out(st_b),
    .cts_irq_out(cts_irq), .rts_irq_out(rts_irq));

  // Steps past edges; 1 ns after the edge both driving and sampling happen.
  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  task automatic check(input string name, input logic [7:0] seen,
                       input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic reset_values;
    check("line_tx", 8'({tx_b, tx_a}), 8'h00);
    check("logic_tx_b", 8'(ltx_b), 8'h01);
    check("rts_dtr", 8'({rts_b, rts_a, dtr_b, dtr_a}), 8'h00);
    check("core_rx", 8'(core_rx), 8'h03);
    check("status", st_a | st_b, 8'h00);
  endtask

  // Sends a space then a mark over channel B and lets the line go idle.
  task automatic tx_walk_b;
    busy = 2'h2;
    core_tx = 2'h1;
    step(2);
    check("tx_b space", 8'({ltx_b, tx_b, tx_a}), 8'h02);
    core_tx = 2'h3;
    step(1);
    check("tx_b mark", 8'({ltx_b, tx_b}), 8'h02);
    busy = 2'h0;
    step(2);
    check("tx_b idle", 8'({ltx_b, tx_b}), 8'h02);
  endtask

  // Holds both channels with clear-to-send low, then frees channel A only;
  // both send spaces so a leak past the gate shows high at the line pin.
  task automatic auto_cts_a;
    feat_a = 8'h80;
    feat_b = 8'h80;
    irq_en_a = 8'h80;
    busy = 2'h3;
    core_tx = 2'h0;
    step(5);
    check("cts gate held", 8'({tx_b, allowed, tx_a}), 8'h00);
    check("cts flags held", 8'({cts_irq[0], st_a[4]}), 8'h02);
    cts_a = 1'b1;
    step(5);
    check("cts gate free", 8'({tx_b, allowed, tx_a}), 8'h03);
    check("cts flags free", 8'({cts_irq[0], st_a[4]}), 8'h01);
    busy = 2'h0;
    feat_a = 8'h00;
    feat_b = 8'h00;
    irq_en_a = 8'h00;
    step(2);
    check("tx idle", 8'({tx_b, tx_a}), 8'h00);
  endtask

  // Software raises request-to-send first, then the core level takes over.
  task automatic auto_rts_b;
    ctrl_b = 8'h02;
    ctrl_a = 8'h03;
    step(1);
    check("rts set", 8'({rts_b, rts_a, dtr_a, dtr_b}), 8'h0e);
    feat_b = 8'h40;
    irq_en_b = 8'h40;
    step(1);
    check("rts stop", 8'({rts_b, rts_irq[1]}), 8'h01);
    rts_lvl = 2'h2;
    step(1);
    check("rts go", 8'({rts_b, rts_irq[1]}), 8'h02);
    ctrl_b = 8'h01;
    ctrl_a = 8'h00;
    step(1);
    check("dtr swap", 8'({rts_b, rts_a, dtr_a, dtr_b}), 8'h01);
  endtask

  task automatic status_pins;
    dsr_a = 1'b1;
    ri_a = 1'b1;
    cd_b = 1'b1;
    step(3);
    check("status a", 8'(st_a[7:5]), 8'h03);
    check("status b", 8'(st_b[7:5]), 8'h04);
    {dsr_a, ri_a, cd_b} = 3'h0;
    step(3);
    check("status open", 8'({st_a[7:5], st_b[7:5]}), 8'h00);
  endtask

  // A space at the selected source must reach receiver B, the other ignored.
  task automatic rx_select_b;
    bit_b = 1'b0;
    bit_a = 1'b0;
    step(3);
    check("rx line", 8'(core_rx), 8'h00);
    sel_b = 1'b1;
    bit_a = 1'b1;
    step(3);
    check("rx logic", 8'(core_rx), 8'h01);
    bit_b = 1'b1;
    sel_b = 1'b0;
    step(3);
    check("rx back", 8'(core_rx), 8'h03);
  endtask

  initial begin
    step(2);
    rst_b_in = 1'b1;
    step(3);
    reset_values();
    tx_walk_b();
    auto_cts_a();
    auto_rts_b();
    status_pins();
    rx_select_b();
    tally_and_finish();
  end

  // The tests need about 40 cycles; 2000 leaves ample slack for a hang.
  initial begin
    repeat (2000) @(posedge clk_in);
    miscompares++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
